// ===== design/ddr_cmd_pkg.sv
`default_nettype none
package ddr_cmd_pkg;

  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int BANKS = 4;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int COL_W = 11;
  localparam int REF_W = ADDR_W + BA_W;

  // Link pins are sampled as one vector; these are the field positions.
  localparam int PIN_DQ_LSB = 0;
  localparam int PIN_DM_LSB = 16;
  localparam int PIN_ADDR_LSB = 18;
  localparam int PIN_BA_LSB = 31;
  localparam int PIN_WE = 33;
  localparam int PIN_CAS = 34;
  localparam int PIN_RAS = 35;
  localparam int PIN_CS = 36;
  localparam int PIN_CKE = 37;
  localparam int PIN_W = 38;

  // Op-code fields of the two mode registers, then address bits of commands.
  localparam int EXT_DLL_OFF_BIT = 0;
  localparam int EXT_DRIVE_BIT = 1;
  localparam int EXT_ISOLATION_BIT = 2;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BL_W = 3;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int COL_X4_BIT = 11;
  localparam int COL_LOW_W = 10;

  localparam logic [BA_W-1:0] BA_BASE = 2'h0;
  localparam logic [BA_W-1:0] BA_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_RESET = 13'h0000;
  localparam logic ORG_X4 = 1'h0;

  // Timing in link clock cycles.
  localparam logic [7:0] DLL_LOCK_CLOCKS = 8'hC8;
  localparam logic [3:0] MODE_SET_TO_COMMAND_DELAY = 4'h2;
  localparam logic [3:0] SELF_REFRESH_EXIT_TO_OTHER_DELAY = 4'hA;
  localparam logic [3:0] ROW_CLOSE_TO_OPEN_DELAY = 4'h3;

  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = BA_W + COL_W + DM_W + DQ_W;

  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_BURST_STOP = 4'h5,
    CMD_PRECHARGE = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_MODE_SET = 4'h8
  } cmd_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                      input logic cas_n, input logic we_n);
    cmd_t c;
    c = CMD_DESELECT;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACTIVE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_BURST_STOP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_REFRESH;
        default: c = CMD_MODE_SET;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // Link clock cycles of one burst: two data elements per cycle.
  function automatic logic [2:0] burst_pairs(input logic [MODE_BL_W-1:0] code);
    logic [2:0] p;
    p = 3'h1;
    if (code == 3'h2) begin
      p = 3'h2;
    end else if (code == 3'h3) begin
      p = 3'h4;
    end
    return p;
  endfunction : burst_pairs

endpackage : ddr_cmd_pkg
`default_nettype wire

// ===== design/ddr_sdram_command_decode.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Extended bits: DLL, drive strength, isolation.
// - Extended mode set loads extended register.
// - Self refresh turns DLL off, exit restores extended setting.
// - Deselect and NOP change nothing.
// - Decode Active, Read, Write, Burst Terminate.
// - Decode Precharge, Refresh, Mode Register Set.
// - CKE high except self refresh entry.
// - Bank bits pick base, extended, or reserved.
// - Active opens addressed row in bank.
// - Bank and column from address pins.
// - A10 closes row after that burst.
// - Masked write elements leave memory unchanged.
// - Precharge one bank or all banks.
// - Precharge to idle or closing bank ignored.
// - Refresh uses internal counter, ignores inputs.
// - Base register: length, type, latency, mode.
module ddr_sdram_command_decode (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Command link from the memory controller.
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ddr_cmd_pkg::BA_W-1:0] ba,
  input wire logic [ddr_cmd_pkg::ADDR_W-1:0] addr,
  input wire logic [ddr_cmd_pkg::DM_W-1:0] dm,
  input wire logic [ddr_cmd_pkg::DQ_W-1:0] dq,
  // Write port toward the memory array.
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [ddr_cmd_pkg::FIFO_W-1:0] mem_wr_word,
  // Mode and DLL status.
  output logic [ddr_cmd_pkg::ADDR_W-1:0] mode_settings,
  output logic [ddr_cmd_pkg::ADDR_W-1:0] extended_mode_settings,
  output logic dll_enabled,
  output logic drive_strength_reduced,
  output logic module_isolation_output,
  output logic read_allowed,
  output logic command_allowed,
  // Bank state.
  output logic [ddr_cmd_pkg::BANKS-1:0] bank_open,
  output logic [ddr_cmd_pkg::BANKS-1:0] bank_closing,
  output logic [ddr_cmd_pkg::BANKS*ddr_cmd_pkg::ADDR_W-1:0] open_rows,
  // Refresh.
  output logic self_refresh_active,
  output logic refresh_pulse,
  output logic [ddr_cmd_pkg::REF_W-1:0] refresh_address,
  // Read burst events and write overflow.
  output logic read_start,
  output logic [ddr_cmd_pkg::BA_W-1:0] read_bank,
  output logic [ddr_cmd_pkg::COL_W-1:0] read_col,
  output logic read_auto_close,
  output logic burst_stop,
  output logic write_overflow
);
  import ddr_cmd_pkg::*;

  typedef struct packed {
    logic [2:0] ck_sync;
    logic ck_level;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [ADDR_W-1:0] mode;
    logic [ADDR_W-1:0] ext;
    logic self_ref;
    logic dll_on;
    logic [7:0] lock_cnt;
    logic read_ok;
    logic [3:0] wait_cnt;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0] closing;
    logic [BANKS-1:0][ADDR_W-1:0] row;
    logic [BANKS-1:0][3:0] close_cnt;
    logic rd_act;
    logic wr_act;
    logic burst_ap;
    logic [BA_W-1:0] burst_bank;
    logic [COL_W-1:0] burst_col;
    logic [2:0] burst_left;
    logic [REF_W-1:0] ref_cnt;
    logic refresh_pulse;
    logic read_start;
    logic burst_stop;
    logic push_valid;
    logic [FIFO_W-1:0] push_word;
    logic overflow;
  } state_t;

  state_t r_reg;
  state_t r_next;
  logic fifo_in_ready;
  logic ck_agree;
  logic edge_now;
  cmd_t cmd_now;
  logic pin_cke;
  logic [BA_W-1:0] pin_ba;
  logic [ADDR_W-1:0] pin_addr;
  logic [DM_W-1:0] pin_dm;
  logic [DQ_W-1:0] pin_dq;
  logic [COL_W-1:0] pin_col;
  logic cmd_live;
  logic mrs_taken;

  // A link edge counts only once the second and third stages agree on the new level.
  assign ck_agree = r_reg.ck_sync[1] == r_reg.ck_sync[2];
  assign edge_now = ck_agree && r_reg.ck_sync[2] && !r_reg.ck_level;
  assign pin_cke = r_reg.pin_s3[PIN_CKE];
  assign pin_ba = r_reg.pin_s3[PIN_BA_LSB +: BA_W];
  assign pin_addr = r_reg.pin_s3[PIN_ADDR_LSB +: ADDR_W];
  assign pin_dm = r_reg.pin_s3[PIN_DM_LSB +: DM_W];
  assign pin_dq = r_reg.pin_s3[PIN_DQ_LSB +: DQ_W];
  assign pin_col = {ORG_X4 & pin_addr[COL_X4_BIT], pin_addr[COL_LOW_W-1:0]};
  assign cmd_now = decode_cmd(r_reg.pin_s3[PIN_CS], r_reg.pin_s3[PIN_RAS],
                              r_reg.pin_s3[PIN_CAS], r_reg.pin_s3[PIN_WE]);
  // Only refresh may arrive with CKE low; anything else then is not executed.
  assign cmd_live = edge_now && !r_reg.self_ref && pin_cke;
  assign mrs_taken = cmd_live && cmd_now == CMD_MODE_SET;

  always_comb begin
    r_next = r_reg;
    r_next.ck_sync = {r_reg.ck_sync[1:0], ck};
    r_next.pin_s1 = {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq};
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_s3 = r_reg.pin_s2;
    if (ck_agree) begin
      r_next.ck_level = r_reg.ck_sync[2];
    end
    r_next.refresh_pulse = 1'b0;
    r_next.read_start = 1'b0;
    r_next.burst_stop = 1'b0;
    r_next.push_valid = 1'b0;
    // A dropped element stays flagged; nothing clears it but reset.
    if (r_reg.push_valid && !fifo_in_ready) begin
      r_next.overflow = 1'b1;
    end
    if (edge_now) begin
      for (int b = 0; b < BANKS; b++) begin
        if (r_reg.closing[b]) begin
          r_next.close_cnt[b] = r_reg.close_cnt[b] - 1'b1;
          if (r_reg.close_cnt[b] == 4'h1) begin
            r_next.closing[b] = 1'b0;
          end
        end
      end
      if (r_reg.dll_on && !r_reg.read_ok) begin
        r_next.lock_cnt = r_reg.lock_cnt + 1'b1;
        r_next.read_ok = (r_reg.lock_cnt + 1'b1) == DLL_LOCK_CLOCKS;
      end
      if (r_reg.wait_cnt != '0) begin
        r_next.wait_cnt = r_reg.wait_cnt - 1'b1;
      end
      if (r_reg.wr_act && pin_dm != '1) begin
        r_next.push_valid = 1'b1;
        r_next.push_word = {r_reg.burst_bank, r_reg.burst_col, pin_dm, pin_dq};
      end
      if (r_reg.rd_act || r_reg.wr_act) begin
        r_next.burst_col = r_reg.burst_col + COL_W'(2);
        r_next.burst_left = r_reg.burst_left - 1'b1;
        if (r_reg.burst_left == 3'h1) begin
          r_next.rd_act = 1'b0;
          r_next.wr_act = 1'b0;
          if (r_reg.burst_ap && r_reg.open[r_reg.burst_bank]) begin
            r_next.open[r_reg.burst_bank] = 1'b0;
            r_next.closing[r_reg.burst_bank] = 1'b1;
            r_next.close_cnt[r_reg.burst_bank] = ROW_CLOSE_TO_OPEN_DELAY;
          end
        end
      end
      if (r_reg.self_ref) begin
        // Every input but CKE is ignored until CKE returns high.
        if (pin_cke) begin
          r_next.self_ref = 1'b0;
          r_next.lock_cnt = '0;
          r_next.read_ok = 1'b0;
          r_next.wait_cnt = SELF_REFRESH_EXIT_TO_OTHER_DELAY;
        end
      end else if (cmd_now == CMD_REFRESH && !pin_cke) begin
        r_next.self_ref = 1'b1;
      end else if (cmd_live) begin
        case (cmd_now)
          CMD_ACTIVE: begin
            // An open or still closing bank keeps its row; the controller must wait.
            if (!r_reg.open[pin_ba] && !r_reg.closing[pin_ba]) begin
              r_next.open[pin_ba] = 1'b1;
              r_next.row[pin_ba] = pin_addr;
            end
          end
          CMD_READ, CMD_WRITE: begin
            if (r_reg.open[pin_ba]) begin
              r_next.rd_act = cmd_now == CMD_READ;
              r_next.wr_act = cmd_now == CMD_WRITE;
              r_next.burst_ap = pin_addr[AUTO_CLOSE_BIT];
              r_next.burst_bank = pin_ba;
              r_next.burst_col = pin_col;
              r_next.burst_left = burst_pairs(r_reg.mode[MODE_BL_LSB +: MODE_BL_W]);
              r_next.read_start = cmd_now == CMD_READ;
            end
          end
          CMD_BURST_STOP: begin
            // Writes and self-closing reads ignore it, since its effect there is undefined.
            if (r_reg.rd_act && !r_reg.burst_ap) begin
              r_next.rd_act = 1'b0;
              r_next.burst_stop = 1'b1;
            end
          end
          CMD_PRECHARGE: begin
            for (int b = 0; b < BANKS; b++) begin
              if (r_reg.open[b] && (pin_addr[AUTO_CLOSE_BIT] || pin_ba == BA_W'(b))) begin
                r_next.open[b] = 1'b0;
                r_next.closing[b] = 1'b1;
                r_next.close_cnt[b] = ROW_CLOSE_TO_OPEN_DELAY;
              end
            end
          end
          CMD_REFRESH: begin
            r_next.ref_cnt = r_reg.ref_cnt + 1'b1;
            r_next.refresh_pulse = 1'b1;
          end
          CMD_MODE_SET: begin
            // Bank state is not checked; loading while busy is the controller's fault.
            if (pin_ba == BA_BASE) begin
              r_next.mode = pin_addr;
            end else if (pin_ba == BA_EXT) begin
              r_next.ext = pin_addr;
              r_next.wait_cnt = MODE_SET_TO_COMMAND_DELAY;
              if (!pin_addr[EXT_DLL_OFF_BIT] && r_reg.ext[EXT_DLL_OFF_BIT]) begin
                r_next.lock_cnt = '0;
                r_next.read_ok = 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    r_next.dll_on = !r_next.ext[EXT_DLL_OFF_BIT] && !r_next.self_ref;
    if (!r_next.dll_on) begin
      r_next.read_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.mode <= MODE_RESET;
      r_reg.ext <= EXT_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ddr_write_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(r_reg.push_valid),
    .in_ready(fifo_in_ready),
    .in_data(r_reg.push_word),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr_word)
  );

  assign mode_settings = r_reg.mode;
  assign extended_mode_settings = r_reg.ext;
  assign dll_enabled = r_reg.dll_on;
  assign drive_strength_reduced = r_reg.ext[EXT_DRIVE_BIT];
  assign module_isolation_output = r_reg.ext[EXT_ISOLATION_BIT];
  assign read_allowed = r_reg.read_ok;
  assign command_allowed = r_reg.wait_cnt == '0;
  assign bank_open = r_reg.open;
  assign bank_closing = r_reg.closing;
  assign open_rows = r_reg.row;
  assign self_refresh_active = r_reg.self_ref;
  assign refresh_pulse = r_reg.refresh_pulse;
  assign refresh_address = r_reg.ref_cnt;
  assign read_start = r_reg.read_start;
  assign read_bank = r_reg.burst_bank;
  assign read_col = r_reg.burst_col;
  assign read_auto_close = r_reg.burst_ap;
  assign burst_stop = r_reg.burst_stop;
  assign write_overflow = r_reg.overflow;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_ext_mode_load:
  assert property (mrs_taken && pin_ba == BA_EXT |=> r_reg.ext == $past(pin_addr))
    else $error("Extended register not loaded.");
  a_base_mode_load:
  assert property (mrs_taken && pin_ba == BA_BASE |=> r_reg.mode == $past(pin_addr)
                   && $stable(r_reg.ext))
    else $error("Base register not loaded.");
  a_reserved_bank_ignored:
  assert property (mrs_taken && pin_ba[1] |=> $stable(r_reg.mode) && $stable(r_reg.ext))
    else $error("Reserved mode target changed a register.");
  a_self_ref_dll:
  assert property (r_reg.self_ref |-> !r_reg.dll_on && !r_reg.read_ok)
    else $error("DLL on during self refresh.");
  a_active_opens_row:
  assert property (cmd_live && cmd_now == CMD_ACTIVE && !r_reg.open[pin_ba]
                   && !r_reg.closing[pin_ba]
                   |=> r_reg.open[$past(pin_ba)] && r_reg.row[$past(pin_ba)] == $past(pin_addr))
    else $error("Active did not open the row.");
  a_precharge_all:
  assert property (cmd_live && cmd_now == CMD_PRECHARGE && pin_addr[AUTO_CLOSE_BIT]
                   |=> r_reg.open == '0)
    else $error("Precharge all left a bank open.");
  a_deselect_stable:
  assert property (edge_now && cmd_now == CMD_DESELECT && !r_reg.self_ref
                   |=> $stable(r_reg.mode) && $stable(r_reg.ext) && $stable(r_reg.ref_cnt))
    else $error("Deselect changed device state.");
  a_refresh_counts:
  assert property (cmd_live && cmd_now == CMD_REFRESH
                   |=> r_reg.ref_cnt == $past(r_reg.ref_cnt) + 1'b1 && r_reg.refresh_pulse)
    else $error("Refresh counter did not advance.");
  a_read_lock_wait:
  assert property (r_reg.read_ok |-> r_reg.lock_cnt == DLL_LOCK_CLOCKS)
    else $error("Reads allowed before DLL lock count.");
  a_mask_drops:
  assert property (r_reg.push_valid |-> r_reg.push_word[DQ_W +: DM_W] != '1)
    else $error("Fully masked element reached the buffer.");
  a_closing_idle:
  assert property (r_reg.closing[0] && cmd_live && cmd_now == CMD_PRECHARGE
                   |=> !r_reg.open[0])
    else $error("Closing bank reopened by precharge.");

endmodule : ddr_sdram_command_decode
`default_nettype wire

// ===== design/ddr_write_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_write_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } fifo_state_t;

  fifo_state_t r_reg;
  fifo_state_t r_next;
  logic push;
  logic pop;

  assign in_ready = r_reg.count != FULL;
  assign out_valid = r_reg.count != '0;
  assign out_data = r_reg.mem[r_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr_ptr] = in_data;
      r_next.wr_ptr = (r_reg.wr_ptr == LAST) ? '0 : r_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      r_next.rd_ptr = (r_reg.rd_ptr == LAST) ? '0 : r_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      r_next.count = r_reg.count + 1'b1;
    end else if (pop && !push) begin
      r_next.count = r_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  a_fifo_no_overrun:
  assert property (@(posedge clk_sys) disable iff (!resetn) r_reg.count <= FULL)
    else $error("Write buffer count above depth.");

endmodule : ddr_write_fifo
`default_nettype wire

// ===== verification/ddr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_ctrl_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Command link toward the device.
  output var logic ck,
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [ddr_cmd_pkg::BA_W-1:0] ba,
  output var logic [ddr_cmd_pkg::ADDR_W-1:0] addr,
  output var logic [ddr_cmd_pkg::DM_W-1:0] dm,
  output var logic [ddr_cmd_pkg::DQ_W-1:0] dq
);
  import ddr_cmd_pkg::*;
  logic [3:0] half_cnt;

  // The link clock runs free; ten system cycles make one half period of 40 ns.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      half_cnt <= 4'h0;
      ck <= 1'b0;
    end else begin
      half_cnt <= (half_cnt == 4'h9) ? 4'h0 : half_cnt + 4'h1;
      if (half_cnt == 4'h9) begin
        ck <= ~ck;
      end
    end
  end

  // Pins change on the falling link edge, so they stand still half a period
  // around every rising edge; the caller owns spacing between commands.
  task automatic send(input logic k, input logic sel_n, input logic [2:0] rcw,
                      input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a,
                      input logic [DM_W-1:0] m, input logic [DQ_W-1:0] d);
    @(posedge clk_sys);
    while (!(half_cnt == 4'h9 && ck)) begin
      @(posedge clk_sys);
    end
    cke <= k;
    cs_n <= sel_n;
    {ras_n, cas_n, we_n} <= rcw;
    ba <= b;
    addr <= a;
    dm <= m;
    dq <= d;
    repeat (19) @(posedge clk_sys);
  endtask : send

  // Idle edges carry NOP; released lines show the inverse of their last value.
  task automatic nop(input int n);
    for (int i = 0; i < n; i++) begin
      send(1'b1, 1'b0, 3'h7, ~ba, ~addr, ~dm, ~dq);
    end
  endtask : nop
endmodule : ddr_ctrl_model
`default_nettype wire

// ===== verification/ddr_sdram_command_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_sdram_command_decode_test;
  import ddr_cmd_pkg::*;
  localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, BST = 3'h6;
  localparam logic [2:0] PRE = 3'h2, REF = 3'h1, MRS = 3'h0, NOP = 3'h7;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic mem_wr_ready = 1'b0;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, mem_wr_valid, dll_enabled;
  logic drive_strength_reduced, module_isolation_output, read_allowed, command_allowed;
  logic self_refresh_active, refresh_pulse, read_start, read_auto_close, burst_stop;
  logic write_overflow;
  logic [BA_W-1:0] ba, read_bank;
  logic [ADDR_W-1:0] addr, mode_settings, extended_mode_settings;
  logic [DM_W-1:0] dm;
  logic [DQ_W-1:0] dq;
  logic [FIFO_W-1:0] mem_wr_word, first_word;
  logic [BANKS-1:0] bank_open, bank_closing;
  logic [BANKS*ADDR_W-1:0] open_rows;
  logic [REF_W-1:0] refresh_address;
  logic [COL_W-1:0] read_col;
  logic [13:0] start_ctx;
  int miscompares = 0, checked = 0, starts = 0, stops = 0, refreshes = 0, drained = 0;

  always #2 clk_sys = ~clk_sys;

  ddr_ctrl_model m (.clk_sys(clk_sys), .resetn(resetn), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm), .dq(dq));

  ddr_sdram_command_decode dut (.clk_sys(clk_sys), .resetn(resetn), .ck(ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm),
    .dq(dq), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_word(mem_wr_word), .mode_settings(mode_settings),
    .extended_mode_settings(extended_mode_settings), .dll_enabled(dll_enabled),
    .drive_strength_reduced(drive_strength_reduced),
    .module_isolation_output(module_isolation_output), .read_allowed(read_allowed),
    .command_allowed(command_allowed), .bank_open(bank_open), .bank_closing(bank_closing),
    .open_rows(open_rows), .self_refresh_active(self_refresh_active),
    .refresh_pulse(refresh_pulse), .refresh_address(refresh_address),
    .read_start(read_start), .read_bank(read_bank), .read_col(read_col),
    .read_auto_close(read_auto_close), .burst_stop(burst_stop),
    .write_overflow(write_overflow));

  // Pulses last one cycle, so they are counted here rather than polled.
  always @(posedge clk_sys) begin
    starts += int'(read_start === 1'b1);
    // The burst context advances during the burst, so it is caught with the start pulse.
    if (read_start === 1'b1) begin
      start_ctx = {read_bank, read_col, read_auto_close};
    end
    stops += int'(burst_stop === 1'b1);
    refreshes += int'(refresh_pulse === 1'b1);
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
      drained++;
      if (drained == 1) begin
        first_word = mem_wr_word;
      end
    end
  end

  task automatic chk(input logic [51:0] got, input logic [51:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a);
    m.send(1'b1, 1'b0, rcw, b, a, ~dm, ~dq);
  endtask : cmd

  task automatic data(input logic [1:0] mask, input logic [15:0] d);
    m.send(1'b1, 1'b0, NOP, ~ba, ~addr, mask, d);
  endtask : data

  // Mode writes are followed by the two idle edges the device needs.
  task automatic mrs(input logic [1:0] b, input logic [12:0] a);
    cmd(MRS, b, a);
    m.nop(2);
  endtask : mrs

  task automatic drain(input int n);
    drained = 0;
    mem_wr_ready <= 1'b1;
    repeat (8) @(posedge clk_sys);
    mem_wr_ready <= 1'b0;
    @(posedge clk_sys);
    chk(52'(drained), 52'(n));
  endtask : drain

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    m.nop(2);
    mrs(2'h0, 13'h0002);
    mrs(2'h2, 13'h1FFF);
    chk(52'(mode_settings), 52'h0002);
    chk(52'(extended_mode_settings), 52'h0);
    cmd(MRS, 2'h1, 13'h0007);
    chk(52'(extended_mode_settings), 52'h0007);
    chk(52'({dll_enabled, drive_strength_reduced, module_isolation_output}), 52'h3);
    m.nop(2);
    cmd(MRS, 2'h1, 13'h0000);
    chk(52'({dll_enabled, command_allowed, read_allowed}), 52'h4);
    m.nop(2);
    chk(52'(command_allowed), 52'h1);
    m.nop(193);
    chk(52'(read_allowed), 52'h0);
    m.nop(10);
    chk(52'(read_allowed), 52'h1);
    $display("test modes done");
    cmd(ACT, 2'h1, 13'h0ABC);
    m.send(1'b1, 1'b1, ACT, 2'h1, 13'h0555, dm, dq);
    chk(52'(bank_open), 52'h2);
    chk(52'(open_rows[25:13]), 52'h0ABC);
    cmd(RD, 2'h1, 13'h0005);
    cmd(BST, 2'h0, 13'h0000);
    chk(52'(start_ctx), 52'h100A);
    chk(52'(starts), 52'h1);
    chk(52'(stops), 52'h1);
    $display("test read done");
    cmd(WR, 2'h1, 13'h0008);
    data(2'h3, 16'h1234);
    data(2'h1, 16'h5678);
    m.nop(1);
    chk(52'(mem_wr_word), 52'(31'h20295678));
    drain(1);
    for (int i = 0; i < 3; i++) begin
      cmd(WR, 2'h1, 13'(4 * i));
      data(2'h0, 16'(2 * i));
      data(2'h0, 16'(2 * i + 1));
    end
    chk(52'(write_overflow), 52'h1);
    drain(4);
    chk(52'(first_word), 52'(31'h20000000));
    $display("test write done");
    cmd(RD, 2'h1, 13'h0400);
    m.nop(4);
    chk(52'(read_auto_close), 52'h1);
    chk(52'(bank_open), 52'h0);
    m.nop(3);
    cmd(PRE, 2'h0, 13'h0000);
    chk(52'(bank_closing), 52'h0);
    cmd(ACT, 2'h0, 13'h0011);
    cmd(ACT, 2'h3, 13'h0033);
    cmd(PRE, 2'h0, 13'h0000);
    chk(52'({bank_open, bank_closing}), 52'h81);
    cmd(PRE, 2'h3, 13'h0400);
    chk(52'({bank_open, bank_closing}), 52'h09);
    m.nop(3);
    $display("test precharge done");
    cmd(REF, 2'h0, 13'h0000);
    chk(52'(refreshes), 52'h1);
    chk(52'(refresh_address), 52'h1);
    m.nop(2);
    m.send(1'b0, 1'b0, REF, 2'h0, 13'h0000, dm, dq);
    chk(52'({self_refresh_active, dll_enabled}), 52'h2);
    m.send(1'b0, 1'b0, ACT, 2'h2, 13'h0222, dm, dq);
    chk(52'(bank_open), 52'h0);
    m.send(1'b1, 1'b1, NOP, 2'h0, 13'h0000, dm, dq);
    chk(52'({self_refresh_active, dll_enabled, command_allowed, read_allowed}), 52'h4);
    m.nop(10);
    chk(52'(command_allowed), 52'h1);
    $display("test refresh done");
    results();
  end
endmodule : ddr_sdram_command_decode_test
`default_nettype wire
